// ==== pkg/ssp_map.svh ====
// register map, field positions, reset values and counts of the shift port
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

`define SSP_DATA_W       8
`define SSP_CNT_W        4
`define SSP_CTRL_W       5
`define SSP_STAT_W       2

`define SSP_IDX_DISARM   10'h0DC
`define SSP_IDX_DATA     10'h0DD
`define SSP_ADDR_DISARM  {`SSP_IDX_DISARM, 2'b00}
`define SSP_ADDR_DATA    {`SSP_IDX_DATA, 2'b00}
`define SSP_ADDR_CTRL    12'h380
`define SSP_ADDR_STAT    12'h384
`define SSP_ADDR_MASK    12'h388
`define SSP_ADDR_CNT     12'h38C

`define SSP_CTRL_OD      0
`define SSP_CTRL_MASTER  1
`define SSP_CTRL_SCL     2
`define SSP_CTRL_ACK     3
`define SSP_CTRL_HOLD    4

`define SSP_STAT_DONE    0
`define SSP_STAT_EXTRA   1

`define SSP_CNT_TERM_BIT 4

`define SSP_RST_DATA     8'h00
`define SSP_RST_CTRL     5'h00
`define SSP_RST_MASK     2'h0
`define SSP_CNT_TERM     4'h8

`endif

// ==== pkg/ssp_pkg.sv ====
// types of the serial shift port
`include "ssp_map.svh"

package ssp_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } ssp_bus_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_DISARM,
    REG_DATA,
    REG_CTRL,
    REG_STAT,
    REG_MASK,
    REG_CNT
  } ssp_reg_t;

  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclLast;
    logic sinMeta;
    logic sinSync;
  } ssp_sync_t;

  typedef struct packed {
    ssp_bus_t                  busSt;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [`SSP_DATA_W-1:0]    shift;
    logic [`SSP_CNT_W-1:0]     cnt;
    logic                      armed;
    logic [`SSP_DATA_W-1:0]    disarmVal;
    logic [`SSP_CTRL_W-1:0]    ctrl;
    logic [`SSP_STAT_W-1:0]    status;
    logic [`SSP_STAT_W-1:0]    mask;
    logic                      irq;
    logic                      irqReqN;
    logic                      sclPrev;
    logic                      soutOut;
    logic                      soutOe;
    logic                      sclOut;
    logic                      sclOe;
    logic                      sinOut;
    logic                      sinOe;
  } ssp_core_t;

endpackage

// ==== pkg/ssp_pin_if.sv ====
// synchronised pin levels and clock edge passed from the sampler to the core
`timescale 1ns/1ps
`default_nettype none

interface ssp_pin_if;
  logic sclLevel;
  logic sclFall;
  logic sinLevel;

  modport sampler (
    output sclLevel,
    output sclFall,
    output sinLevel
  );

  modport core (
    input sclLevel,
    input sclFall,
    input sinLevel
  );
endinterface

`default_nettype wire

// ==== core/ssp_pin_sync.sv ====
// two-stage sampler for the shift clock and serial input pins
`timescale 1ns/1ps
`default_nettype none

module ssp_pin_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sclIn,
  input  wire logic sinIn,
  ssp_pin_if.sampler pin
);

  ssp_pkg::ssp_sync_t st;
  ssp_pkg::ssp_sync_t next_st;

  // **********************************************************
  // sampling
  // **********************************************************
  // meta stages feed only the second stage; edges use stages two and three
  always_comb begin
    next_st = st;
    next_st.sclMeta = sclIn;
    next_st.sclSync = st.sclMeta;
    next_st.sclLast = st.sclSync;
    next_st.sinMeta = sinIn;
    next_st.sinSync = st.sinMeta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin.sclLevel = st.sclSync;
  assign pin.sclFall  = st.sclLast & ~st.sclSync; // R3
  assign pin.sinLevel = st.sinSync;

endmodule // ssp_pin_sync

`default_nettype wire

// ==== core/ssp_shift_port.sv ====
// serial shift port: shift engine, arm logic, pins and apb register slave
//
// Notes on behaviour
// R1: an 8-bit data/shift register and a 4-bit clock pulse counter.
// R2: serial output presents the most significant bit first.
// R3: shift register and counter advance on each falling shift clock edge.
// R4: slave mode: clock pin is an input, the far party supplies edges.
// R5: master mode: software makes each edge by setting and clearing the line.
// R6: after eight pulses the terminal output falls and stops all clocking.
// R7: interrupt on eighth falling edge unless a data write reset the count.
// R8: after reset interrupt generation is disarmed.
// R9: any data register write arms the interrupt for eight further pulses; the code acts on a data write only when pstrb[0] is set.
// R10: any write to the disarm register disarms interrupt generation; the code acts on a disarm write only when pstrb[0] is set.
// R11: interrupt request is signalled by a high-to-low transition.
// R12: reset or data write clears the counter and enables clocking.
// R13: software keeps serial input as input, output as open drain.
// R14: open-drain mode routes the shift register msb onto the output pin.
// R15: software may pull serial input low and hold clock low to acknowledge.
// R16: an unused port gets no data writes, maybe a dummy disarm write.
// R17: each enabled edge shifts toward msb, serial input enters the lsb.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"

module ssp_shift_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  output var  logic        irqReqN,
  input  wire logic        sclIn,
  output var  logic        sclOut,
  output var  logic        sclOe,
  input  wire logic        sinIn,
  output var  logic        sinOut,
  output var  logic        sinOe,
  input  wire logic        soutIn,
  output var  logic        soutOut,
  output var  logic        soutOe
);

  // **********************************************************
  // state
  // **********************************************************
  ssp_pkg::ssp_core_t st;
  ssp_pkg::ssp_core_t next_st;

  ssp_pin_if pin ();

  logic                   fall;
  logic                   running;
  logic [`SSP_CNT_W-1:0]  cntInc;
  logic [`SSP_STAT_W-1:0] setBits;
  logic [`SSP_STAT_W-1:0] clrBits;
  logic [31:0]            rdMux;
  ssp_pkg::ssp_reg_t      sel;

  // **********************************************************
  // pin sampler
  // **********************************************************
  // sout readback is a plain port line, not used by the shifter
  ssp_pin_sync u_sync (
    .clk   (clk),
    .srst  (srst),
    .sclIn (sclIn),
    .sinIn (sinIn),
    .pin   (pin.sampler)
  );

  // **********************************************************
  // address decode
  // **********************************************************
  function automatic ssp_pkg::ssp_reg_t regDecode(
    input logic [11:0] addr
  );
    ssp_pkg::ssp_reg_t r;
    r = ssp_pkg::REG_NONE;
    case (addr)
      `SSP_ADDR_DISARM: begin
        r = ssp_pkg::REG_DISARM;
      end
      `SSP_ADDR_DATA: begin
        r = ssp_pkg::REG_DATA;
      end
      `SSP_ADDR_CTRL: begin
        r = ssp_pkg::REG_CTRL;
      end
      `SSP_ADDR_STAT: begin
        r = ssp_pkg::REG_STAT;
      end
      `SSP_ADDR_MASK: begin
        r = ssp_pkg::REG_MASK;
      end
      `SSP_ADDR_CNT: begin
        r = ssp_pkg::REG_CNT;
      end
      default: begin
        r = ssp_pkg::REG_NONE;
      end
    endcase
    return r;
  endfunction

  // **********************************************************
  // next state
  // **********************************************************
  always_comb begin
    next_st = st;
    setBits = '0;
    clrBits = '0;
    sel     = regDecode(paddr);
    cntInc  = st.cnt + 4'h1;

    // master mode takes the edge from the software-driven level, since
    // the pin loopback would add the sampler delay to every bit
    if (st.ctrl[`SSP_CTRL_MASTER]) begin // R5
      fall = st.sclPrev & ~st.ctrl[`SSP_CTRL_SCL];
    end else begin // R4
      fall = pin.sclFall;
    end
    next_st.sclPrev = st.ctrl[`SSP_CTRL_SCL];

    // terminal output: high while fewer than eight pulses were counted
    running = ~st.cnt[`SSP_CNT_W-1]; // R6

    // shift engine
    if (fall) begin
      if (running) begin
        next_st.shift = {st.shift[`SSP_DATA_W-2:0], pin.sinLevel}; // R17
        next_st.cnt   = cntInc; // R1
        if (cntInc == `SSP_CNT_TERM && st.armed) begin // R7
          setBits[`SSP_STAT_DONE] = 1'b1;
          next_st.irqReqN = 1'b0; // R11
        end
      end else begin
        // clock gated off: a ninth pulse only leaves a trace in status
        setBits[`SSP_STAT_EXTRA] = 1'b1; // R6
      end
    end

    // read data
    case (sel)
      ssp_pkg::REG_DISARM: begin
        rdMux = {24'h000000, st.disarmVal};
      end
      ssp_pkg::REG_DATA: begin
        rdMux = {24'h000000, st.shift}; // R17
      end
      ssp_pkg::REG_CTRL: begin
        rdMux = {27'h0000000, st.ctrl};
      end
      ssp_pkg::REG_STAT: begin
        rdMux = {30'h00000000, st.status};
      end
      ssp_pkg::REG_MASK: begin
        rdMux = {30'h00000000, st.mask};
      end
      ssp_pkg::REG_CNT: begin
        rdMux = {27'h0000000, running, st.cnt};
      end
      default: begin
        rdMux = 32'h00000000;
      end
    endcase

    // apb slave: one wait cycle, effects land on the completing edge
    case (st.busSt)
      ssp_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          next_st.pready  = 1'b1;
          next_st.pslverr = (sel == ssp_pkg::REG_NONE);
          next_st.prdata  = rdMux;
          next_st.busSt   = ssp_pkg::BUS_ANSWER;
        end
      end
      ssp_pkg::BUS_ANSWER: begin
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h00000000;
        next_st.busSt   = ssp_pkg::BUS_IDLE;
        if (psel && penable && pwrite && pstrb[0]) begin
          case (sel)
            ssp_pkg::REG_DATA: begin
              // a write wins over a clock edge in the same cycle
              next_st.shift   = pwdata[`SSP_DATA_W-1:0];
              next_st.cnt     = '0; // R12
              next_st.armed   = 1'b1; // R9
              next_st.irqReqN = 1'b1;
              setBits[`SSP_STAT_DONE] = 1'b0; // R7
            end
            ssp_pkg::REG_DISARM: begin
              next_st.disarmVal = pwdata[`SSP_DATA_W-1:0];
              next_st.armed     = 1'b0; // R10
              next_st.irqReqN   = 1'b1;
              setBits[`SSP_STAT_DONE] = 1'b0;
            end
            ssp_pkg::REG_CTRL: begin
              next_st.ctrl = pwdata[`SSP_CTRL_W-1:0];
            end
            ssp_pkg::REG_MASK: begin
              next_st.mask = pwdata[`SSP_STAT_W-1:0];
            end
            default: begin
              next_st.ctrl = st.ctrl;
            end
          endcase
        end
        // clear only what the read reported, so a bit set meanwhile stays
        if (psel && penable && !pwrite && sel == ssp_pkg::REG_STAT) begin
          clrBits = st.prdata[`SSP_STAT_W-1:0];
        end
      end
      default: begin
        next_st.busSt = ssp_pkg::BUS_IDLE;
      end
    endcase

    // sticky status, set wins over clear
    next_st.status = (st.status & ~clrBits) | setBits;
    next_st.irq    = |(next_st.status & next_st.mask);

    // pins: all three lines are open drain, only ever pulled low
    next_st.soutOut = 1'b0;
    next_st.soutOe  = next_st.ctrl[`SSP_CTRL_OD] & ~next_st.shift[7]; // R14 R2
    next_st.sinOut  = 1'b0;
    next_st.sinOe   = next_st.ctrl[`SSP_CTRL_ACK]; // R15
    next_st.sclOut  = 1'b0;
    next_st.sclOe   = (next_st.ctrl[`SSP_CTRL_MASTER]
                       & ~next_st.ctrl[`SSP_CTRL_SCL])
                      | next_st.ctrl[`SSP_CTRL_HOLD]; // R5 R15
  end

  // **********************************************************
  // registers
  // **********************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st           <= '0;
      st.shift     <= `SSP_RST_DATA;
      st.ctrl      <= `SSP_RST_CTRL;
      st.mask      <= `SSP_RST_MASK;
      st.cnt       <= '0; // R12
      st.armed     <= 1'b0; // R8
      st.irqReqN   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // **********************************************************
  // outputs
  // **********************************************************
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign irq     = st.irq;
  assign irqReqN = st.irqReqN;
  assign sclOut  = st.sclOut;
  assign sclOe   = st.sclOe;
  assign sinOut  = st.sinOut;
  assign sinOe   = st.sinOe;
  assign soutOut = st.soutOut;
  assign soutOe  = st.soutOe;

endmodule // ssp_shift_port

`default_nettype wire

// ==== test/ssp_shift_port_sva.sv ====
// assertion checker for the shift port apb answers and pins
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.svh"

module ssp_shift_port_sva (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irqReqN,
  input wire logic        sclIn,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sinOut,
  input wire logic        sinOe,
  input wire logic        soutOut
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic wrArm  = wrDone && (paddr == `SSP_ADDR_DATA ||
                                 paddr == `SSP_ADDR_DISARM);
  wire logic wrCtl  = wrDone && paddr == `SSP_ADDR_CTRL;

  sequence s_taken; psel && penable && !pready; endsequence
  sequence s_answer; pready && psel && penable; endsequence

  property p_answer; s_taken |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_sel; pready |-> s_answer; endproperty
  a_sel: assert property (p_sel) else $error("ready without access");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer carries data");
  property p_rise; $rose(irqReqN) |-> $past(wrArm) || $past(wrArm, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("request rose unasked");
  property p_hold; !irqReqN && !wrArm && !$past(wrArm) |=> !irqReqN;
  endproperty
  a_hold: assert property (p_hold) else $error("request not held");
  // master edges come from the register, seen first as the clock pin pulled
  property p_fall; $fell(irqReqN) |-> (!$past(sclIn, 2) && $past(sclIn, 6))
    || ($past(sclOe) && !$past(sclOe, 2));
  endproperty
  a_fall: assert property (p_fall) else $error("request without edge");
  property p_od; !sclOut && !sinOut && !soutOut; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_scl; $changed(sclOe) |-> $past(wrCtl) || $past(wrCtl, 2);
  endproperty
  a_scl: assert property (p_scl) else $error("clock pin moved unasked");
  property p_sin; $changed(sinOe) |-> $past(wrCtl) || $past(wrCtl, 2);
  endproperty
  a_sin: assert property (p_sin) else $error("input pin moved unasked");
endmodule // ssp_shift_port_sva

bind ssp_shift_port ssp_shift_port_sva u_sva (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .irqReqN, .sclIn, .sclOut, .sclOe, .sinOut, .sinOe, .soutOut
);

`default_nettype wire

// ==== test/ssp_far_end.sv ====
// far-end serial device: clocks frames msb first, samples the output line
`timescale 1ns/1ps
`default_nettype none

module ssp_far_end (
  input  wire logic       soutLine,
  output var  logic       sclDrv,
  output var  logic       sinDrv,
  output var  logic [7:0] rxByte
);
  // ****************
  // frame generator
  // ****************
  // clock stands high between frames, data released to its pull-up
  initial begin
    sclDrv = 1'b1;
    sinDrv = 1'b1;
    rxByte = 8'h00;
  end

  // the 1 ns lead keeps link edges off the core clock edge
  task automatic frame(input logic [7:0] tx, input int n, input int half = 40);
    #1;
    for (int i = 0; i < n; i++) begin
      sinDrv = (i < 8) ? tx[7 - i] : 1'b1;
      #half;
      rxByte = {rxByte[6:0], soutLine};
      sclDrv = 1'b0;
      #half;
      sclDrv = 1'b1;
    end
    #40;
    sinDrv = 1'b1;
  endtask
endmodule // ssp_far_end

`default_nettype wire

// ==== test/tb_ssp_shift_port.sv ====
// self-checking bench of the serial shift port
`timescale 1ns/1ps
`default_nettype none

module tb_ssp_shift_port;
  localparam logic [11:0] aDis = 12'h370;
  localparam logic [11:0] aDat = 12'h374;
  localparam logic [11:0] aCtl = 12'h380;
  localparam logic [11:0] aSta = 12'h384;
  localparam logic [11:0] aMsk = 12'h388;
  localparam logic [11:0] aCnt = 12'h38C;
  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, irqReqN;
  logic        sclOut, sclOe, sinOut, sinOe, soutOut, soutOe;
  logic        sclDrv, sinDrv;
  logic [7:0]  rxByte;
  int          nErrors    = 0;
  int          checksDone = 0;
  // open-drain lines with pull-ups
  wire logic   sclLine  = sclDrv & ~sclOe;
  wire logic   sinLine  = sinDrv & ~sinOe;
  wire logic   soutLine = ~soutOe;

  always #2 clk = ~clk;

  ssp_shift_port DUT (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .irq, .irqReqN,
    .sclIn(sclLine), .sclOut, .sclOe, .sinIn(sinLine), .sinOut, .sinOe,
    .soutIn(soutLine), .soutOut, .soutOe
  );
  ssp_far_end far (.soutLine, .sclDrv, .sinDrv, .rxByte);

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe = 1'b0);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'b0, 32'h0, q, e);
    chk(q, x);
    chkb(e, xe);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d, errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    #100000;
    nErrors++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(aCtl, 32'h00);
    rd(aSta, 32'h00);
    rd(aMsk, 32'h00);
    rd(aCnt, 32'h10);
    rd(aDat, 32'h00);
    rd(12'h3F0, 32'h0, 1'b1);
    chkb(irqReqN, 1'b1);
    // slave byte in both directions, then a refused ninth edge
    wr(aMsk, 32'h1);
    wr(aCtl, 32'h1);
    wr(aDat, 32'hA5);
    far.frame(8'h3C, 8);
    chk({24'h0, rxByte}, 32'hA5);
    rd(aDat, 32'h3C);
    rd(aCnt, 32'h08);
    chkb(irqReqN, 1'b0);
    chkb(irq, 1'b1);
    far.frame(8'hFF, 1);
    rd(aDat, 32'h3C);
    rd(aSta, 32'h3);
    rd(aSta, 32'h0);
    chkb(irq, 1'b0);
    wr(aDis, 32'h5A);
    settle;
    chkb(irqReqN, 1'b1);
    rd(aDis, 32'h5A);
    // disarm after arming: no request at the eighth edge
    wr(aDat, 32'h00);
    wr(aDis, 32'h00);
    far.frame(8'hFF, 8);
    chkb(irqReqN, 1'b1);
    rd(aSta, 32'h0);
    // data write mid-byte restarts the count, masked status
    wr(aMsk, 32'h0);
    wr(aDat, 32'h81);
    far.frame(8'h00, 4);
    wr(aDat, 32'h81);
    far.frame(8'h00, 4);
    chkb(irqReqN, 1'b1);
    rd(aCnt, 32'h14);
    far.frame(8'h00, 4);
    chkb(irqReqN, 1'b0);
    chkb(irq, 1'b0);
    rd(aSta, 32'h1);
    // master clock made by register writes
    wr(aCtl, 32'h2);
    settle;
    chkb(sclOe, 1'b1);
    wr(aDat, 32'h00);
    for (int i = 0; i < 8; i++) begin
      wr(aCtl, 32'h6);
      wr(aCtl, 32'h2);
    end
    settle;
    chkb(irqReqN, 1'b0);
    rd(aDat, 32'hFF);
    wr(aCtl, 32'h18);
    settle;
    chkb(sinOe, 1'b1);
    chkb(sclOe, 1'b1);
    conclude();
  end
endmodule // tb_ssp_shift_port

`default_nettype wire
